// file: qmec_cfg.svh
/*
 * constants for the quad mode entry and exit control block: opcodes,
 * byte positions, parameter-table contents and the register map.
 * assumes it is included by bare name after the package is compiled.
 */
// Behaviour
// - with quad io enable high, hold and write-protect pins lose their control role
// - quad io enable lives in bit 1 of status_reg_two
// - opcode 05h returns status register one, 35h returns status_reg_two
// - write status 01h with two bytes, second byte bit 1 high, sets quad enable
// - same two-byte write with second byte bit 1 low clears quad enable
// - quad read mode byte with upper nibble Ah enters continuous 0-4-4 read
// - mode byte 00h ends continuous read after the current read
// - all ones on quad_data_lines for 8 clocks ends continuous read
// - with quad enable set, opcode 38h enters four-wire instruction mode
// - opcode FFh in four-wire mode returns to single-wire instructions
// - reset-enable 66h then reset 99h also ends four-wire mode
// - parameter bytes 69h to 6Bh read back F6h, DDh, FFh
// - soft reset acts only when 99h directly follows 66h, on current width
`ifndef QMEC_CFG_SVH
`define QMEC_CFG_SVH

// -------------------------------------------------------------
// link opcodes
// -------------------------------------------------------------
`define QMEC_OP_RDSR1 8'h05
`define QMEC_OP_RDSR2 8'h35
`define QMEC_OP_WRSR 8'h01
`define QMEC_OP_QPI_ENTER 8'h38
`define QMEC_OP_QPI_EXIT 8'hff
`define QMEC_OP_RST_EN 8'h66
`define QMEC_OP_RST 8'h99
`define QMEC_OP_SFDP 8'h5a
`define QMEC_OP_QIO_READ 8'heb

// -------------------------------------------------------------
// framing: byte positions counted from the opcode byte
// -------------------------------------------------------------
`define QMEC_POS_OPCODE 3'h0
`define QMEC_POS_ADDR_LAST 3'h3
`define QMEC_POS_WRSR_SECOND 3'h2
`define QMEC_POS_MODE 3'h4
`define QMEC_POS_SFDP_DUMMY 3'h4
`define QMEC_POS_MAX 3'h6
`define QMEC_BIT_LAST_SINGLE 3'h7
`define QMEC_BIT_LAST_QUAD 3'h1
`define QMEC_CNT_MAX 6'h3f
`define QMEC_MBR_LAST_CLK 6'h07
`define QMEC_NIB_ALL_ONES 4'hf
`define QMEC_NIB_MODE_ENTER 4'ha
`define QMEC_QE_BIT 1
`define QMEC_WIP_BIT 0
`define QMEC_DQ_SINGLE_OUT 4'h2
`define QMEC_DQ_QUAD_OUT 4'hf
`define QMEC_HOLD_PIN 3
`define QMEC_WP_PIN 2

// -------------------------------------------------------------
// parameter table bytes held by this block
// -------------------------------------------------------------
`define QMEC_SFDP_ADDR_A 24'h000069
`define QMEC_SFDP_ADDR_B 24'h00006a
`define QMEC_SFDP_ADDR_C 24'h00006b
`define QMEC_SFDP_DATA_A 8'hf6
`define QMEC_SFDP_DATA_B 8'hdd
`define QMEC_SFDP_DATA_C 8'hff
`define QMEC_SFDP_BLANK 8'hff

// -------------------------------------------------------------
// software register map (byte addresses) and fields
// -------------------------------------------------------------
`define QMEC_REG_CTRL 8'h00
`define QMEC_REG_STAT 8'h04
`define QMEC_CTRL_BUSY 0
`define QMEC_STAT_QE 0
`define QMEC_STAT_QPI 1
`define QMEC_STAT_CRM 2
`define QMEC_STAT_HOLD 3
`define QMEC_STAT_WP 4
`define QMEC_STAT_W 5

`endif

// file: qmec_pkg.sv
/*
 * types shared by the quad mode entry and exit control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package qmec_pkg;

   // -------------------------------------------------------------
   // link operating mode
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      QMEC_MODE_SPI = 2'b00,  // single-wire instructions
      QMEC_MODE_CRM = 2'b01,  // continuous 0-4-4 read, opcode skipped
      QMEC_MODE_QPI = 2'b10   // four-wire instructions
   } qmec_mode_t;

endpackage : qmec_pkg

// file: qmec_sync2.sv
/*
 * two flip-flop level synchroniser, one stage pair per bit.
 * assumes each bit is a slow level; multi-bit words are not coherent.
 */
`timescale 1ns/1ps
module qmec_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_in,           // destination clock
   input wire logic rst_b_in,         // async reset, active low
   input wire logic [W-1:0] d_in,     // level from the other domain
   output logic [W-1:0] q_out         // synchronised level
);
   logic [W-1:0] meta_reg;

   // -------------------------------------------------------------
   // first stage feeds only the second
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule : qmec_sync2

// file: qmec_sfdp_rom.sv
/*
 * parameter-table bytes for quad enable and mode entry and exit.
 * assumes relative byte addresses; all other bytes read as blank.
 */
`timescale 1ns/1ps
`include "qmec_cfg.svh"
module qmec_sfdp_rom (
   input wire logic [23:0] addr_in,   // relative byte address
   output logic [7:0] data_out        // table byte
);
   // -------------------------------------------------------------
   // fixed lookup, bytes outside this block's part are blank
   // -------------------------------------------------------------
   always_comb begin
      unique case (addr_in)
         `QMEC_SFDP_ADDR_A: data_out = `QMEC_SFDP_DATA_A;
         `QMEC_SFDP_ADDR_B: data_out = `QMEC_SFDP_DATA_B;
         `QMEC_SFDP_ADDR_C: data_out = `QMEC_SFDP_DATA_C;
         default: data_out = `QMEC_SFDP_BLANK;
      endcase
   end
endmodule : qmec_sfdp_rom

// file: qmec_top.sv
/*
 * quad mode entry and exit control: serial link decoder on the link
 * clock, holding quad enable, four-wire mode and continuous read state,
 * plus a small software register port on the system clock.
 * assumes spi mode 0 with the link clock idle outside frames and the
 * chip select high between frames; array reads are handled elsewhere.
 */
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "qmec_cfg.svh"
module qmec_top (
   input wire logic CLK_IN,               // system clock, 10 MHz
   input wire logic RST_B_IN,             // async reset, active low
   input wire logic [7:0] REG_ADDR_IN,    // register byte address
   input wire logic [31:0] REG_WDATA_IN,  // register write data
   input wire logic REG_WR_IN,            // write strobe
   input wire logic REG_RD_IN,            // read strobe
   output logic [31:0] REG_RDATA_OUT,     // read data, cycle after strobe
   input wire logic SCLK_IN,              // link clock from host
   input wire logic CS_B_IN,              // link chip select, active low
   input wire logic [3:0] DQ_IN,          // quad_data_lines input side
   output logic [3:0] DQ_OUT,             // quad_data_lines output side
   output logic [3:0] DQ_OE_OUT,          // high while driving a line
   output logic QUAD_ENABLE_OUT,          // quad_io_enable_bit, synced
   output logic HOLD_ACTIVE_OUT,          // hold function asserted
   output logic WRITE_PROTECT_OUT         // write-protect function asserted
);
   // link domain state
   qmec_pkg::qmec_mode_t mode_reg;
   qmec_pkg::qmec_mode_t mode_next;
   logic qe_reg;
   logic rst_en_reg;
   logic [5:0] cnt_reg;
   logic [2:0] bc_reg;
   logic [2:0] pos_reg;
   logic [7:0] acc_reg;
   logic [7:0] cmd_reg;
   logic [23:0] addr_reg;
   logic [7:0] tx_reg;
   logic tx_on_reg;
   logic txq_reg;
   logic frame_crm_reg;
   logic ones_reg;
   // link domain combinational terms
   logic frame_rst_b;
   logic first;
   logic crm_cur;
   logic [2:0] pos_eff;
   logic [7:0] cmd_cur;
   logic [7:0] op;
   logic quad;
   logic [7:0] acc_next;
   logic byte_done;
   logic ones_next;
   logic paused;
   logic wp_on;
   logic load_ok;
   logic [7:0] sr1;
   logic [7:0] sr2;
   logic [7:0] rom_data;
   logic [7:0] out_byte;
   logic busy_link;
   // system domain
   logic ctrl_busy_reg;
   logic [`QMEC_STAT_W-1:0] stat_raw;
   logic [`QMEC_STAT_W-1:0] stat_sync;

   // -------------------------------------------------------------
   // frame decode helpers
   // -------------------------------------------------------------
   // chip select high ends the frame even though the link clock stops
   assign frame_rst_b = RST_B_IN & ~CS_B_IN;
   assign first = (cnt_reg == 6'h00);
   // continuous read is latched at the first clock so a mid-frame exit
   // does not change how the rest of this frame is parsed
   assign crm_cur = first ? (mode_reg == qmec_pkg::QMEC_MODE_CRM) : frame_crm_reg;
   assign pos_eff = crm_cur ? pos_reg + 3'h1 : pos_reg;
   assign cmd_cur = crm_cur ? `QMEC_OP_QIO_READ : cmd_reg;
   assign op = (pos_eff == `QMEC_POS_OPCODE) ? acc_next : cmd_cur;
   // with quad enable set, quad read bytes after the opcode travel on all four lines
   assign quad = (mode_reg == qmec_pkg::QMEC_MODE_QPI) ||
                 ((cmd_cur == `QMEC_OP_QIO_READ) && qe_reg &&
                  (pos_eff != `QMEC_POS_OPCODE));
   assign acc_next = quad ? {acc_reg[3:0], DQ_IN} : {acc_reg[6:0], DQ_IN[0]};
   assign byte_done = (bc_reg == (quad ? `QMEC_BIT_LAST_QUAD : `QMEC_BIT_LAST_SINGLE));
   assign ones_next = (first || ones_reg) && (DQ_IN == `QMEC_NIB_ALL_ONES);
   // hold and write protect only while quad enable is low
   assign paused = ~qe_reg & ~DQ_IN[`QMEC_HOLD_PIN];
   assign wp_on = ~qe_reg & ~DQ_IN[`QMEC_WP_PIN];
   assign load_ok = (op == `QMEC_OP_RDSR1) || (op == `QMEC_OP_RDSR2) ||
                    ((op == `QMEC_OP_SFDP) && (pos_eff >= `QMEC_POS_SFDP_DUMMY));

   // status bytes as seen on the link
   always_comb begin
      sr1 = 8'h00;
      sr2 = 8'h00;
      sr1[`QMEC_WIP_BIT] = busy_link;
      sr2[`QMEC_QE_BIT] = qe_reg;
   end

   qmec_sfdp_rom u_rom (
      .addr_in(addr_reg),
      .data_out(rom_data)
   );

   // next byte to shift out
   always_comb begin
      if (op == `QMEC_OP_RDSR1) begin
         out_byte = sr1;
      end else if (op == `QMEC_OP_RDSR2) begin
         out_byte = sr2;
      end else begin
         out_byte = rom_data;
      end
   end

   // -------------------------------------------------------------
   // per-frame shifting, cleared by chip select
   // -------------------------------------------------------------
   always_ff @(posedge SCLK_IN or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         cnt_reg <= 6'h00;
         bc_reg <= 3'h0;
         pos_reg <= 3'h0;
         acc_reg <= 8'h00;
         cmd_reg <= 8'h00;
         frame_crm_reg <= 1'b0;
         ones_reg <= 1'b0;
      end else if (!paused) begin
         cnt_reg <= (cnt_reg == `QMEC_CNT_MAX) ? cnt_reg : cnt_reg + 6'h01;
         ones_reg <= ones_next;
         acc_reg <= acc_next;
         if (first) begin
            frame_crm_reg <= (mode_reg == qmec_pkg::QMEC_MODE_CRM);
         end
         if (byte_done) begin
            bc_reg <= 3'h0;
            pos_reg <= (pos_reg == `QMEC_POS_MAX) ? pos_reg : pos_reg + 3'h1;
            if (pos_eff == `QMEC_POS_OPCODE) begin
               cmd_reg <= acc_next;
            end
         end else begin
            bc_reg <= bc_reg + 3'h1;
         end
      end
   end

   // address capture and parameter-table walk
   always_ff @(posedge SCLK_IN or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         addr_reg <= 24'h000000;
      end else if (!paused && byte_done) begin
         if ((pos_eff != `QMEC_POS_OPCODE) && (pos_eff <= `QMEC_POS_ADDR_LAST)) begin
            addr_reg <= {addr_reg[15:0], acc_next};
         end else if (load_ok && (op == `QMEC_OP_SFDP)) begin
            addr_reg <= addr_reg + 24'h000001;
         end
      end
   end

   // output shifter; status bytes repeat until the frame ends
   always_ff @(posedge SCLK_IN or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         tx_reg <= 8'h00;
         tx_on_reg <= 1'b0;
         txq_reg <= 1'b0;
      end else if (!paused) begin
         if (byte_done && load_ok) begin
            tx_reg <= out_byte;
            tx_on_reg <= 1'b1;
            txq_reg <= quad;
         end else if (tx_on_reg) begin
            tx_reg <= txq_reg ? {tx_reg[3:0], 4'h0} : {tx_reg[6:0], 1'b0};
         end
      end
   end

   // single-wire answers use line 1; quad answers use all four lines
   assign DQ_OUT = txq_reg ? tx_reg[7:4] : {2'b00, tx_reg[7], 1'b0};
   assign DQ_OE_OUT = tx_on_reg ? (txq_reg ? `QMEC_DQ_QUAD_OUT : `QMEC_DQ_SINGLE_OUT)
                                : 4'h0;

   // -------------------------------------------------------------
   // persistent link state: mode, quad enable, reset arm
   // -------------------------------------------------------------
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         qmec_pkg::QMEC_MODE_SPI: begin
            if (byte_done && (pos_eff == `QMEC_POS_OPCODE)) begin
               if ((acc_next == `QMEC_OP_QPI_ENTER) && qe_reg) begin
                  mode_next = qmec_pkg::QMEC_MODE_QPI;
               end
            end else if (byte_done && (pos_eff == `QMEC_POS_MODE) &&
                         (cmd_cur == `QMEC_OP_QIO_READ) && qe_reg &&
                         (acc_next[7:4] == `QMEC_NIB_MODE_ENTER)) begin
               mode_next = qmec_pkg::QMEC_MODE_CRM;
            end
         end
         qmec_pkg::QMEC_MODE_CRM: begin
            // the fh reset ends on the same clock as the mode byte, so the
            // all-ones check takes priority over any nibble decode
            if ((cnt_reg == `QMEC_MBR_LAST_CLK) && crm_cur && ones_next) begin
               mode_next = qmec_pkg::QMEC_MODE_SPI;
            end else if (byte_done && (pos_eff == `QMEC_POS_MODE) &&
                         (acc_next[7:4] != `QMEC_NIB_MODE_ENTER)) begin
               mode_next = qmec_pkg::QMEC_MODE_SPI;  // frame still finishes
            end
         end
         qmec_pkg::QMEC_MODE_QPI: begin
            if (byte_done && (pos_eff == `QMEC_POS_OPCODE)) begin
               if (acc_next == `QMEC_OP_QPI_EXIT) begin
                  mode_next = qmec_pkg::QMEC_MODE_SPI;
               end else if ((acc_next == `QMEC_OP_RST) && rst_en_reg) begin
                  mode_next = qmec_pkg::QMEC_MODE_SPI;
               end
            end
         end
         default: mode_next = qmec_pkg::QMEC_MODE_SPI;
      endcase
   end

   always_ff @(posedge SCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         mode_reg <= qmec_pkg::QMEC_MODE_SPI;
      end else if (!paused) begin
         mode_reg <= mode_next;
      end
   end

   // reset arm: any other opcode in between disarms it
   always_ff @(posedge SCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_en_reg <= 1'b0;
      end else if (!paused && byte_done && (pos_eff == `QMEC_POS_OPCODE) && !crm_cur) begin
         rst_en_reg <= (acc_next == `QMEC_OP_RST_EN);
      end
   end

   // quad enable from the second write-status byte; write protect blocks it
   always_ff @(posedge SCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         qe_reg <= 1'b0;
      end else if (!paused && byte_done && !wp_on && (cmd_cur == `QMEC_OP_WRSR) &&
                   (pos_eff == `QMEC_POS_WRSR_SECOND)) begin
         qe_reg <= acc_next[`QMEC_QE_BIT];
      end
   end

   // -------------------------------------------------------------
   // crossings between the two domains (levels only)
   // -------------------------------------------------------------
   qmec_sync2 #(.W(1)) u_busy_sync (
      .clk_in(SCLK_IN),
      .rst_b_in(RST_B_IN),
      .d_in(ctrl_busy_reg),
      .q_out(busy_link)
   );

   always_comb begin
      stat_raw = '0;
      stat_raw[`QMEC_STAT_QE] = qe_reg;
      stat_raw[`QMEC_STAT_QPI] = (mode_reg == qmec_pkg::QMEC_MODE_QPI);
      stat_raw[`QMEC_STAT_CRM] = (mode_reg == qmec_pkg::QMEC_MODE_CRM);
      stat_raw[`QMEC_STAT_HOLD] = ~DQ_IN[`QMEC_HOLD_PIN];
      stat_raw[`QMEC_STAT_WP] = ~DQ_IN[`QMEC_WP_PIN];
   end

   qmec_sync2 #(.W(`QMEC_STAT_W)) u_stat_sync (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .d_in(stat_raw),
      .q_out(stat_sync)
   );

   // -------------------------------------------------------------
   // system side outputs and register port
   // -------------------------------------------------------------
   // pin functions vanish once quad enable is set
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         QUAD_ENABLE_OUT <= 1'b0;
         HOLD_ACTIVE_OUT <= 1'b0;
         WRITE_PROTECT_OUT <= 1'b0;
      end else begin
         QUAD_ENABLE_OUT <= stat_sync[`QMEC_STAT_QE];
         HOLD_ACTIVE_OUT <= ~stat_sync[`QMEC_STAT_QE] & stat_sync[`QMEC_STAT_HOLD];
         WRITE_PROTECT_OUT <= ~stat_sync[`QMEC_STAT_QE] & stat_sync[`QMEC_STAT_WP];
      end
   end

   // busy flag shown to the host in status register one
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         ctrl_busy_reg <= 1'b0;
      end else if (REG_WR_IN && (REG_ADDR_IN == `QMEC_REG_CTRL)) begin
         ctrl_busy_reg <= REG_WDATA_IN[`QMEC_CTRL_BUSY];
      end
   end

   // read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         REG_RDATA_OUT <= 32'h00000000;
      end else if (REG_RD_IN && (REG_ADDR_IN == `QMEC_REG_CTRL)) begin
         REG_RDATA_OUT <= {31'h00000000, ctrl_busy_reg};
      end else if (REG_RD_IN && (REG_ADDR_IN == `QMEC_REG_STAT)) begin
         REG_RDATA_OUT <= {{(32 - `QMEC_STAT_W){1'b0}}, stat_sync};
      end else begin
         REG_RDATA_OUT <= 32'h00000000;
      end
   end
endmodule : qmec_top

// file: qmec_properties.sv
/* checker for the quad mode entry and exit block: register port and line drive.
   assumes it sees only the top module ports; bound at the foot of this file. */
`timescale 1ns/1ps
module qmec_properties (
   input wire logic CLK_IN,               // system clock
   input wire logic RST_B_IN,             // async reset, active low
   input wire logic [7:0] REG_ADDR_IN,    // register address
   input wire logic [31:0] REG_WDATA_IN,  // write data
   input wire logic REG_WR_IN,            // write strobe
   input wire logic REG_RD_IN,            // read strobe
   input wire logic [31:0] REG_RDATA_OUT, // read data
   input wire logic CS_B_IN,              // link chip select
   input wire logic [3:0] DQ_OE_OUT,      // line drive enables
   input wire logic QUAD_ENABLE_OUT,      // quad_io_enable_bit
   input wire logic HOLD_ACTIVE_OUT,      // hold function
   input wire logic WRITE_PROTECT_OUT     // write-protect function
);
   // ---------------------------------------------
   // register port
   // ---------------------------------------------
   rd_idle_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      !REG_RD_IN |=> REG_RDATA_OUT == 32'h0) else $error("read data outside answer");
   rd_unmap_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      REG_RD_IN && !(REG_ADDR_IN inside {8'h00, 8'h04}) |=> REG_RDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   stat_high_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      REG_RD_IN && REG_ADDR_IN == 8'h04 |=> REG_RDATA_OUT[31:5] == 27'h0)
      else $error("status upper bits set");
   ctrl_back_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (REG_WR_IN && REG_ADDR_IN == 8'h00) ##1 (REG_RD_IN && REG_ADDR_IN == 8'h00)
      |=> REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & 32'h1)) else $error("busy readback");
   // ---------------------------------------------
   // line drive and pin roles
   // ---------------------------------------------
   cs_release_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      CS_B_IN |-> DQ_OE_OUT == 4'h0) else $error("lines driven while deselected");
   oe_stands_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      !CS_B_IN && DQ_OE_OUT != 4'h0 |=> CS_B_IN || $stable(DQ_OE_OUT))
      else $error("answer drive dropped in frame");
   quad_drive_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (QUAD_ENABLE_OUT == 1'b0)[*6] |-> DQ_OE_OUT inside {4'h0, 4'h2})
      else $error("quad lines driven without quad enable");
   pins_off_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      QUAD_ENABLE_OUT[*6] |-> !HOLD_ACTIVE_OUT && !WRITE_PROTECT_OUT)
      else $error("pin functions active with quad enable");
endmodule : qmec_properties

bind qmec_top qmec_properties u_props (
   .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .CS_B_IN(CS_B_IN), .DQ_OE_OUT(DQ_OE_OUT),
   .QUAD_ENABLE_OUT(QUAD_ENABLE_OUT), .HOLD_ACTIVE_OUT(HOLD_ACTIVE_OUT),
   .WRITE_PROTECT_OUT(WRITE_PROTECT_OUT));

// file: qmec_host_model.sv
/* host serial controller model: link clock, chip select and host line drive.
   assumes the bench resolves the lines; clock idles low outside frames. */
`timescale 1ns/1ps
module qmec_host_model (
   output logic sclk_out,        // link clock, still between frames
   output logic cs_b_out,        // chip select, active low
   output logic [3:0] dq_out,    // host drive values
   output logic [3:0] dq_oe_out, // host drive enables
   input wire logic [3:0] dq_in  // resolved line levels
);
   logic [3:0] pins = 4'hf;
   initial begin
      sclk_out = 1'b0;
      cs_b_out = 1'b1;
      dq_out = 4'hf;
      dq_oe_out = 4'hd;
   end
   // idle levels of hold and write-protect, used between and in frames
   task set_pins(input logic [3:0] v);
      pins = v;
      dq_out = v;
   endtask : set_pins
   // one byte; quad answers release all four lines to the device
   task xfer(input logic [7:0] b, input logic q, input logic rd, output logic [7:0] x);
      dq_oe_out = q ? (rd ? 4'h0 : 4'hf) : 4'hd;
      for (int k = 0; k < (q ? 2 : 8); k++) begin
         dq_out = q ? b[7-4*k -: 4] : {pins[3:1], b[7-k]};
         #62.5;
         x = q ? {x[3:0], dq_in} : {x[6:0], dq_in[1]};
         sclk_out = 1'b1;
         #62.5;
         sclk_out = 1'b0;
      end
   endtask : xfer
   // whole frames only, chip select high between them
   task frame(input logic [7:0] qm, input logic [63:0] b, input int n, input int nr,
              output logic [23:0] r);
      logic [7:0] x;
      cs_b_out = 1'b0;
      #62.5;
      for (int i = 0; i < n + nr; i++) begin
         xfer(i < n ? b[8*(n-1-i) +: 8] : 8'h00, qm[i], i >= n, x);
         r = {r[15:0], x};
      end
      cs_b_out = 1'b1;
      dq_oe_out = 4'hd;
      dq_out = pins;
      #250;
   endtask : frame
endmodule : qmec_host_model

// file: tb_top.sv
/* bench for the quad mode entry and exit block: register calls and link frames.
   assumes the host model drives the link; lines are resolved here. */
`timescale 1ns/1ps
module tb_top;
   logic clk, rst_b, wr, rd, sclk, cs_b, qe, hold, wp;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] dq_o, dq_oe, h_dq, h_oe;
   logic [23:0] r;
   wire [3:0] dq_w;
   int n_errors = 0;
   int n_checks = 0;
   // undriven lines show the inverse of the device value, never a held level
   assign dq_w = (dq_oe & dq_o) | (~dq_oe & h_oe & h_dq) | (~dq_oe & ~h_oe & ~dq_o);
   qmec_top dut (.CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .SCLK_IN(sclk), .CS_B_IN(cs_b), .DQ_IN(dq_w), .DQ_OUT(dq_o), .DQ_OE_OUT(dq_oe),
      .QUAD_ENABLE_OUT(qe), .HOLD_ACTIVE_OUT(hold), .WRITE_PROTECT_OUT(wp));
   qmec_host_model host (.sclk_out(sclk), .cs_b_out(cs_b), .dq_out(h_dq),
      .dq_oe_out(h_oe), .dq_in(dq_w));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", s, e, g);
         n_errors++;
      end
   endtask : chk
   task reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   // now skips the wait so a read can follow a write with no gap
   task reg_rd(input logic [7:0] a, input bit now);
      if (!now) @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : reg_rd
   // status lags the link by a few clocks through the synchronisers
   task stat(input logic [31:0] e);
      repeat (6) @(posedge clk);
      reg_rd(8'h04, 1'b0);
      chk("stat", e, d);
   endtask : stat
   task fr(input logic [7:0] q, input logic [63:0] b, input int n, input int nr);
      host.frame(q, b, n, nr, r);
   endtask : fr
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end
   initial begin
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      stat(32'h0);
      reg_rd(8'h08, 1'b0);
      chk("unmapped", 32'h0, d);
      reg_wr(8'h00, 32'h1);
      reg_rd(8'h00, 1'b1);
      chk("ctrl", 32'h1, d);
      reg_wr(8'h04, 32'h1f);
      stat(32'h0);
      fr(8'h00, 64'h05, 1, 1);
      chk("sr1", 32'h01, r[7:0]);
      $display("test registers done");
      host.set_pins(4'h7);
      stat(32'h08);
      chk("hold", 32'h1, hold);
      host.set_pins(4'hb);
      fr(8'h00, 64'h010002, 3, 0);
      stat(32'h10);
      chk("wp", 32'h1, wp);
      host.set_pins(4'hf);
      $display("test pins done");
      fr(8'h00, 64'h010002, 3, 0);
      stat(32'h01);
      chk("qe out", 32'h1, qe);
      fr(8'h00, 64'h35, 1, 1);
      chk("sr2", 32'h02, r[7:0]);
      host.set_pins(4'h3);
      stat(32'h19);
      chk("hold off", 32'h0, {hold, wp});
      host.set_pins(4'hf);
      $display("test quad enable done");
      fr(8'h00, 64'h38, 1, 0);
      stat(32'h03);
      fr(8'hff, 64'h35, 1, 1);
      chk("quad sr2", 32'h02, r[7:0]);
      fr(8'hff, 64'hff, 1, 0);
      stat(32'h01);
      fr(8'h00, 64'h38, 1, 0);
      fr(8'hff, 64'h66, 1, 0);
      fr(8'hff, 64'h05, 1, 1);
      chk("quad sr1", 32'h01, r[7:0]);
      fr(8'hff, 64'h99, 1, 0);
      stat(32'h03);
      fr(8'hff, 64'h66, 1, 0);
      fr(8'hff, 64'h99, 1, 0);
      stat(32'h01);
      reg_wr(8'h00, 32'h0);
      $display("test four-wire done");
      fr(8'h00, 64'h5a00006900, 5, 3);
      chk("table", 32'hf6ddff, r);
      fr(8'h1e, 64'heb000000a5, 5, 0);
      stat(32'h05);
      fr(8'hff, 64'h00000000, 4, 0);
      stat(32'h01);
      fr(8'h1e, 64'heb000000a0, 5, 0);
      stat(32'h05);
      fr(8'hff, 64'hffffffff, 4, 0);
      stat(32'h01);
      $display("test continuous read done");
      fr(8'h00, 64'h010000, 3, 0);
      stat(32'h00);
      chk("qe clr", 32'h0, qe);
      fr(8'h00, 64'h38, 1, 0);
      stat(32'h00);
      $display("test quad clear done");
      // a reset in mid-run must drop quad enable and four-wire mode
      fr(8'h00, 64'h010002, 3, 0);
      fr(8'h00, 64'h38, 1, 0);
      stat(32'h03);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      stat(32'h00);
      chk("qe reset", 32'h0, qe);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule : tb_top
